/* crossbar_switch_with_bridges_tb_top.sv */
// Purpose: Self-checking bench of the crossbar switch.
// Assumes: Masters are driven here; targets come from the behavioural model.
// Notes:   Each access waits for its ack under a bounded count.
`timescale 1ns/1ps
`include "xbar_defs.svh"
module crossbar_switch_with_bridges_tb_top;
	logic             sys_clk;
	logic             rst_n;
	logic [3:0]       dly;
	logic [4:0]       m_req, m_we, m_byte, m_ack, t_req, t_we, t_byte, t_ack, drop, seen;
	logic [4:0][31:0] m_addr, m_wdata, m_rdata, t_addr, t_wdata, t_rdata;
	logic             br_rst;
	logic [31:0]      last_rd [5];
	int               ack_at [5];
	int               failures, checked, cyc;

	xbar_switch DUT (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_m_req(m_req), .i_m_we(m_we), .i_m_byte(m_byte),
		.i_m_addr(m_addr), .i_m_wdata(m_wdata), .o_m_ack(m_ack), .o_m_rdata(m_rdata), .o_t_req(t_req),
		.o_t_we(t_we), .o_t_byte(t_byte), .o_t_addr(t_addr), .o_t_wdata(t_wdata), .i_t_ack(t_ack),
		.i_t_rdata(t_rdata), .o_memory_bridge_reset(br_rst));
	xbar_tgt_model TGT (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_dly(dly), .i_req(t_req), .i_addr(t_addr),
		.o_ack(t_ack), .o_rdata(t_rdata));

	// =====================================================================
	// Clock, monitors and helpers
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// Acks are sampled mid-cycle; the release of req waits for the next rising edge.
	always @(negedge sys_clk) begin
		seen = seen | t_req;
		for (int m = 0; m < 5; m++) if (m_ack[m] === 1'b1) begin
			ack_at[m]  = cyc;
			last_rd[m] = m_rdata[m];
			drop[m]    = 1'b1;
		end
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		for (int m = 0; m < 5; m++) if (drop[m]) begin
			m_req[m] <= 1'b0;
			drop[m]  = 1'b0;
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic start(input int m, input logic we, input logic byt, input logic [31:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		m_req[m]   <= 1'b1;
		m_we[m]    <= we;
		m_byte[m]  <= byt;
		m_addr[m]  <= a;
		m_wdata[m] <= wd;
		ack_at[m]  = 0;
		seen       = '0;
	endtask
	task automatic wait_ack(input int m);
		int n;
		n = 0;
		while (ack_at[m] == 0 && n < 200) begin
			@(negedge sys_clk);
			n++;
		end
		chk("ack arrived", 32'h1, {31'h0, ack_at[m] != 0});
		@(posedge sys_clk);
	endtask
	task automatic rd(input int m, input logic byt, input logic [31:0] a, input logic [31:0] exp, input logic [31:0] msk,
		input logic [4:0] exp_tgt);
		start(m, 1'b0, byt, a, 32'h0);
		wait_ack(m);
		chk("read data", exp, last_rd[m] & msk);
		chk("target hit", {27'h0, exp_tgt}, {27'h0, seen});
	endtask
	task automatic launch(input logic [4:0] msk, input logic [4:0][31:0] a);
		@(posedge sys_clk);
		for (int m = 0; m < 5; m++) if (msk[m]) begin
			m_req[m]  <= 1'b1;
			m_we[m]   <= 1'b0;
			m_byte[m] <= 1'b0;
			m_addr[m] <= a[m];
			ack_at[m] = 0;
		end
	endtask
	task close_out;
		if (failures == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// =====================================================================
	// Scenarios
	task automatic t_reset;
		chk("bridge reset pin", 32'h1, {31'h0, br_rst});
		rd(0, 1'b0, `XB_BRIDGE_CTRL, 32'h1, 32'h1, 5'h0);
	endtask
	task automatic t_route;
		logic [31:0] ad [17] = '{32'h0000_0000, 32'h0004_0004, 32'h1003_FFFC, 32'h1004_0000, 32'h2000_0000,
			32'h2000_0000, 32'h6200_8090, 32'h4000_0084, 32'h4A00_0010, 32'h56FF_FFFC, 32'h5400_0000,
			32'h6100_8080, 32'h6100_81FC, 32'h8000_0000, 32'h9FFF_FFFC, 32'hF000_00BC, 32'hA000_0000};
		logic        by [17] = '{0, 1, 0, 0, 0, 1, 0, 0, 0, 0, 1, 0, 1, 0, 1, 0, 0};
		int          tg [17] = '{0, 0, 0, 7, 2, 7, 7, 7, 2, 3, 7, 7, 4, 1, 1, 2, 7};
		for (int i = 0; i < 17; i++)
			rd(0, by[i], ad[i], tg[i] == 7 ? 32'h0 : ad[i] ^ 32'h5A5A_0000, 32'hFFFF_FFFF,
				tg[i] == 7 ? 5'h0 : 5'h1 << tg[i]);
	endtask
	task automatic t_bridge;
		start(3, 1'b0, 1'b0, 32'h1000_0000, 32'h0);
		repeat (10) @(negedge sys_clk);
		chk("host stalled", 32'h0, {27'h0, seen[0], 4'h0} | ack_at[3]);
		start(0, 1'b1, 1'b0, `XB_BRIDGE_CTRL, 32'h0);
		wait_ack(0);
		chk("bridge released", 32'h0, {31'h0, br_rst});
		wait_ack(3);
		chk("host data", 32'h1000_0000 ^ 32'h5A5A_0000, last_rd[3]);
		rd(0, 1'b0, `XB_BRIDGE_CTRL, 32'h0, 32'h1, 5'h0);
	endtask
	task automatic t_arb;
		logic [4:0][31:0] a;
		for (int m = 0; m < 5; m++) a[m] = 32'h8000_0000 + 32'(m * 4);
		dly <= 4'h3;
		launch(5'h1E, a);
		wait_ack(4);
		chk("order", 32'h1, {31'h0, ack_at[1] < ack_at[2] && ack_at[2] < ack_at[3] && ack_at[3] < ack_at[4]});
		for (int m = 1; m < 5; m++) chk("arb data", a[m] ^ 32'h5A5A_0000, last_rd[m]);
		start(4, 1'b0, 1'b0, 32'h8000_0100, 32'h0);
		repeat (2) @(negedge sys_clk);
		start(0, 1'b0, 1'b0, 32'h8000_0200, 32'h0);
		wait_ack(0);
		chk("owner kept", 32'h1, {31'h0, ack_at[4] != 0 && ack_at[4] < ack_at[0]});
		dly <= 4'h0;
		a[0] = 32'h4000_0000;
		a[1] = 32'h5400_0000;
		launch(5'h03, a);
		wait_ack(1);
		wait_ack(0);
		chk("parallel", 32'(ack_at[1]), 32'(ack_at[0]));
	endtask
	// A byte write must reach the target with all its fields; setting the bridge reset aborts a host access.
	task automatic t_write;
		dly <= 4'h2;
		start(2, 1'b1, 1'b1, 32'h8000_0011, 32'h0000_00A5);
		repeat (2) @(negedge sys_clk);
		chk("target we", 32'h1, {31'h0, t_we[1]});
		chk("target byte", 32'h1, {31'h0, t_byte[1]});
		chk("target wdata", 32'h0000_00A5, t_wdata[1]);
		chk("target addr", 32'h8000_0011, t_addr[1]);
		wait_ack(2);
		chk("write rdata", 32'h0, last_rd[2]);
		dly <= 4'h8;
		start(3, 1'b0, 1'b0, 32'h1000_0000, 32'h0);
		start(0, 1'b1, 1'b0, `XB_BRIDGE_CTRL, 32'h1);
		wait_ack(0);
		wait_ack(3);
		chk("abort data", 32'h0, last_rd[3]);
		chk("bridge set", 32'h1, {31'h0, br_rst});
		dly <= 4'h0;
		start(0, 1'b1, 1'b0, `XB_BRIDGE_CTRL, 32'h0);
		wait_ack(0);
		chk("bridge cleared", 32'h0, {31'h0, br_rst});
	endtask

	// =====================================================================
	// Main sequence and watchdog
	initial begin
		{rst_n, m_req, m_we, m_byte, m_addr, m_wdata, drop, seen, dly} = '0;
		{failures, checked, cyc} = '0;
		foreach (ack_at[m]) ack_at[m] = 0;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_route();
		t_bridge();
		t_arb();
		t_write();
		close_out();
	end
	initial begin
		#2_000_000;
		failures++;
		close_out();
	end
endmodule // crossbar_switch_with_bridges_tb_top

/* xbar_defs.svh */
// Purpose: Address map, field positions and reset values of the crossbar switch.
// Assumes: 32-bit byte addresses; every bound is inclusive.
// Notes:   Definitions only.
`ifndef XBAR_DEFS_SVH
`define XBAR_DEFS_SVH

// =====================================================================
// Sizes
`define XB_NUM_MST         5
`define XB_NUM_TGT         5
`define XB_IDX_W           3

// =====================================================================
// Master indices, listed in falling priority
`define XB_M_CPU           3'h0
`define XB_M_HIDMA         3'h1
`define XB_M_LODMA         3'h2
`define XB_M_HOST          3'h3
`define XB_M_PFILL         3'h4

// =====================================================================
// Address map
`define XB_ROM_END         32'h0005_FFFF
`define XB_RAM_BASE        32'h1000_0000
`define XB_RAM_END         32'h1003_FFFF
`define XB_EXT_BASE        32'h8000_0000
`define XB_EXT_END         32'h9FFF_FFFF
`define XB_CACHE_BASE      32'h2000_0000
`define XB_CACHE_END       32'h2000_001F
`define XB_CFG_BASE        32'h4000_0000
`define XB_CFG_END         32'h4000_0083
`define XB_EXTREG_BASE     32'hF000_0000
`define XB_EXTREG_END      32'hF000_00BF
`define XB_PER_FIRST       8'h41
`define XB_PER_LAST        8'h4A
`define XB_AUD_FIRST       8'h54
`define XB_AUD_LAST        8'h56
`define XB_DMACTL_BASE     32'h6000_0000
`define XB_DMACTL_END      32'h6000_008F
`define XB_DMATBL_HI       8'h61
`define XB_DMATBL_LO       8'h62
`define XB_EVT_BASE        24'h00_8000
`define XB_EVT_END         24'h00_807F
`define XB_XFR_BASE        24'h00_80A0
`define XB_XFR_END         24'h00_81FF

// =====================================================================
// Bridge control register
`define XB_BRIDGE_CTRL     32'h4000_0024
`define XB_BRIDGE_RST_BIT  0
`define XB_BRIDGE_RST_INIT 1'h1

`endif

/* xbar_pkg.sv */
// Purpose: Types shared by the crossbar switch modules.
// Assumes: xbar_defs.svh supplies the sizes.
// Notes:   Target codes beyond the five groups mark local answers.
`include "xbar_defs.svh"
package xbar_pkg;

	typedef enum logic [2:0] {
		TGT_ONCHIP,
		TGT_EXTERNAL_MEMORY_INTERFACE,
		TGT_PERIPH,
		TGT_AUDIO,
		TGT_DMA,
		TGT_LOCAL,
		TGT_NONE
	} target_t;

	typedef struct packed {
		logic [`XB_NUM_TGT-1:0]                    own_vld;
		logic [`XB_NUM_TGT-1:0][`XB_IDX_W-1:0]     own_idx;
		logic [`XB_NUM_TGT-1:0]                    t_req;
		logic [`XB_NUM_TGT-1:0]                    t_we;
		logic [`XB_NUM_TGT-1:0]                    t_byte;
		logic [`XB_NUM_TGT-1:0][31:0]              t_addr;
		logic [`XB_NUM_TGT-1:0][31:0]              t_wdata;
		logic [`XB_NUM_MST-1:0]                    m_ack;
		logic [`XB_NUM_MST-1:0][31:0]              m_rdata;
		logic                                      bridge_rst;
	} xbar_state_t;

endpackage

/* xbar_prio_arb.sv */
// Purpose: Fixed-priority pick of one requester for one target.
// Assumes: Index 0 has the highest priority.
// Notes:   Purely combinational; ownership is held by the caller.
`timescale 1ns/1ps
`include "xbar_defs.svh"
module xbar_prio_arb (
	input  wire logic [`XB_NUM_MST-1:0] i_req,
	output logic                        o_any,
	output logic [`XB_IDX_W-1:0]        o_idx
);

	// Scanning downward lets the lowest index overwrite any other pick.
	always_comb begin
		o_any = |i_req;
		o_idx = '0;
		for (int m = `XB_NUM_MST - 1; m >= 0; m--) begin
			if (i_req[m]) begin
				o_idx = m[`XB_IDX_W-1:0];
			end
		end
	end

endmodule // xbar_prio_arb

/* xbar_switch.sv */
// Purpose: Crossbar switch joining five bus masters to five target groups.
// Assumes: One clock; a master holds its request steady until its ack pulse.
// Notes:   Targets answer a held request with a one-cycle ack.
//
// Contract
// - Five masters reach five targets; different targets run in parallel.
// - Simultaneous contenders: highest priority wins, others stall.
// - An owner keeps the target until its access completes; no preemption. Here setting the bridge reset aborts a DMA or host owner of on-chip memory.
// - High-priority DMA port beats low-priority DMA port.
// - Program fill has fifth, lowest priority at external memory.
// - A bridge stage sits between masters and targets of differing clocks.
// - Memory bridge feeds on-chip memory; program-fill bridge feeds external memory.
// - External memory bridge and CPU data bridge drive targets on peripheral timing.
// - Bridge control bit 0 holds the memory bridge in reset; resets to 1.
// - Upper bridge control bits read indeterminate; software writes zeros.
// - ROM pages and RAM route to the on-chip memory slave port.
// - SDRAM and flash windows route to the external memory interface.
// - Audio data windows route to the audio DMA bus, word only.
// - Configuration registers and peripheral blocks use the configuration bus, word only.
// - Memory and cache control region accepts word accesses only.
// - DMA transfer and event tables, with the gap between them reserved.
// - External memory controller registers are a peripheral register target.
`timescale 1ns/1ps
`include "xbar_defs.svh"
module xbar_switch (
	input  wire logic                                 i_sys_clk,
	input  wire logic                                 i_rst_n,
	input  wire logic [`XB_NUM_MST-1:0]               i_m_req,
	input  wire logic [`XB_NUM_MST-1:0]               i_m_we,
	input  wire logic [`XB_NUM_MST-1:0]               i_m_byte,
	input  wire logic [`XB_NUM_MST-1:0][31:0]         i_m_addr,
	input  wire logic [`XB_NUM_MST-1:0][31:0]         i_m_wdata,
	output logic      [`XB_NUM_MST-1:0]               o_m_ack,
	output logic      [`XB_NUM_MST-1:0][31:0]         o_m_rdata,
	output logic      [`XB_NUM_TGT-1:0]               o_t_req,
	output logic      [`XB_NUM_TGT-1:0]               o_t_we,
	output logic      [`XB_NUM_TGT-1:0]               o_t_byte,
	output logic      [`XB_NUM_TGT-1:0][31:0]         o_t_addr,
	output logic      [`XB_NUM_TGT-1:0][31:0]         o_t_wdata,
	input  wire logic [`XB_NUM_TGT-1:0]               i_t_ack,
	input  wire logic [`XB_NUM_TGT-1:0][31:0]         i_t_rdata,
	output logic                                      o_memory_bridge_reset
);

	// =====================================================================
	// Address decode

	xbar_pkg::xbar_state_t                     cur;
	xbar_pkg::xbar_state_t                     nxt;
	xbar_pkg::target_t [`XB_NUM_MST-1:0]       tgt_sel;
	logic [`XB_NUM_MST-1:0]                    busy_m;
	logic [`XB_NUM_MST-1:0]                    elig;
	logic [`XB_NUM_TGT-1:0][`XB_NUM_MST-1:0]   tgt_req;
	logic [`XB_NUM_TGT-1:0]                    arb_any;
	logic [`XB_NUM_TGT-1:0][`XB_IDX_W-1:0]     arb_idx;
	logic                                      abort_onchip;

	// Word-only regions refuse byte access by treating it as unmapped.
	function automatic xbar_pkg::target_t decode(input logic [31:0] a, input logic b);
		xbar_pkg::target_t t;
		t = xbar_pkg::TGT_NONE;
		if (a <= `XB_ROM_END || (a >= `XB_RAM_BASE && a <= `XB_RAM_END)) begin
			t = xbar_pkg::TGT_ONCHIP;
		end else if (a >= `XB_EXT_BASE && a <= `XB_EXT_END) begin
			t = xbar_pkg::TGT_EXTERNAL_MEMORY_INTERFACE;
		end else if (a == `XB_BRIDGE_CTRL) begin
			t = b ? xbar_pkg::TGT_NONE : xbar_pkg::TGT_LOCAL;
		end else if ((a >= `XB_CFG_BASE && a <= `XB_CFG_END) ||
				(a >= `XB_CACHE_BASE && a <= `XB_CACHE_END) ||
				(a >= `XB_EXTREG_BASE && a <= `XB_EXTREG_END) ||
				(a[31:24] >= `XB_PER_FIRST && a[31:24] <= `XB_PER_LAST)) begin
			t = b ? xbar_pkg::TGT_NONE : xbar_pkg::TGT_PERIPH;
		end else if (a[31:24] >= `XB_AUD_FIRST && a[31:24] <= `XB_AUD_LAST) begin
			t = b ? xbar_pkg::TGT_NONE : xbar_pkg::TGT_AUDIO;
		end else if (a >= `XB_DMACTL_BASE && a <= `XB_DMACTL_END) begin
			t = b ? xbar_pkg::TGT_NONE : xbar_pkg::TGT_DMA;
		end else if ((a[31:24] == `XB_DMATBL_HI || a[31:24] == `XB_DMATBL_LO) &&
				((a[23:0] >= `XB_EVT_BASE && a[23:0] <= `XB_EVT_END) ||
				(a[23:0] >= `XB_XFR_BASE && a[23:0] <= `XB_XFR_END))) begin
			t = xbar_pkg::TGT_DMA;
		end
		return t;
	endfunction

	// A master already owning a target, or acked this cycle, may not be granted again.
	always_comb begin
		busy_m = '0;
		for (int t = 0; t < `XB_NUM_TGT; t++) begin
			if (cur.own_vld[t]) begin
				busy_m[cur.own_idx[t]] = 1'b1;
			end
		end
	end

	// =====================================================================
	// Per-target arbitration

	genvar gt;
	genvar gm;
	generate
		for (gm = 0; gm < `XB_NUM_MST; gm++) begin : g_mst
			assign tgt_sel[gm] = decode(i_m_addr[gm], i_m_byte[gm]);
			assign elig[gm]    = i_m_req[gm] && !cur.m_ack[gm] && !busy_m[gm];
		end
		for (gt = 0; gt < `XB_NUM_TGT; gt++) begin : g_tgt
			for (gm = 0; gm < `XB_NUM_MST; gm++) begin : g_req
				// While the memory bridge is in reset the DMA and host ports stall on it.
				assign tgt_req[gt][gm] = elig[gm] && (int'(tgt_sel[gm]) == gt) &&
					!(gt == int'(xbar_pkg::TGT_ONCHIP) && cur.bridge_rst &&
					gm != int'(`XB_M_CPU) && gm != int'(`XB_M_PFILL));
			end
			// Index order gives CPU, high DMA, low DMA, host, then program fill.
			xbar_prio_arb u_arb (
				.i_req (tgt_req[gt]),
				.o_any (arb_any[gt]),
				.o_idx (arb_idx[gt])
			);
		end
	endgenerate

	assign abort_onchip = cur.bridge_rst && cur.own_vld[xbar_pkg::TGT_ONCHIP] &&
		cur.own_idx[xbar_pkg::TGT_ONCHIP] != `XB_M_CPU &&
		cur.own_idx[xbar_pkg::TGT_ONCHIP] != `XB_M_PFILL;

	// =====================================================================
	// Next state

	always_comb begin
		nxt       = cur;
		nxt.m_ack = '0;
		for (int t = 0; t < `XB_NUM_TGT; t++) begin
			if (cur.own_vld[t]) begin
				// Ownership ends only on the target's ack or an on-chip abort, so no later winner can cut in.
				if (i_t_ack[t] || (t == int'(xbar_pkg::TGT_ONCHIP) && abort_onchip)) begin
					nxt.own_vld[t]                 = 1'b0;
					nxt.t_req[t]                   = 1'b0;
					nxt.m_ack[cur.own_idx[t]]      = 1'b1;
					nxt.m_rdata[cur.own_idx[t]]    = (cur.t_we[t] || !i_t_ack[t]) ? '0 : i_t_rdata[t];
				end
			end else if (arb_any[t]) begin
				// The registered target stage is the bridge between master and target timing.
				nxt.own_vld[t] = 1'b1;
				nxt.own_idx[t] = arb_idx[t];
				nxt.t_req[t]   = 1'b1;
				nxt.t_we[t]    = i_m_we[arb_idx[t]];
				nxt.t_byte[t]  = i_m_byte[arb_idx[t]];
				nxt.t_addr[t]  = i_m_addr[arb_idx[t]];
				nxt.t_wdata[t] = i_m_wdata[arb_idx[t]];
			end
		end
		for (int m = 0; m < `XB_NUM_MST; m++) begin
			if (elig[m] && tgt_sel[m] == xbar_pkg::TGT_LOCAL) begin
				nxt.m_ack[m]   = 1'b1;
				// Upper bits read as zero; only the reset bit is stored.
				nxt.m_rdata[m] = '0;
				nxt.m_rdata[m][`XB_BRIDGE_RST_BIT] = cur.bridge_rst;
				if (i_m_we[m]) begin
					nxt.bridge_rst = i_m_wdata[m][`XB_BRIDGE_RST_BIT];
				end
			end else if (elig[m] && tgt_sel[m] == xbar_pkg::TGT_NONE) begin
				nxt.m_ack[m]   = 1'b1;
				nxt.m_rdata[m] = '0;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cur            <= '0;
			cur.bridge_rst <= `XB_BRIDGE_RST_INIT;
		end else begin
			cur <= nxt;
		end
	end

	assign o_m_ack               = cur.m_ack;
	assign o_m_rdata             = cur.m_rdata;
	assign o_t_req               = cur.t_req;
	assign o_t_we                = cur.t_we;
	assign o_t_byte              = cur.t_byte;
	assign o_t_addr              = cur.t_addr;
	assign o_t_wdata             = cur.t_wdata;
	assign o_memory_bridge_reset = cur.bridge_rst;

	// =====================================================================
	// Assertions

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	ack_single_pulse_a: assert property ((o_m_ack & $past(o_m_ack)) == '0)
		else $error("master ack lasted two cycles");

	ext_decode_range_a: assert property (o_t_req[xbar_pkg::TGT_EXTERNAL_MEMORY_INTERFACE] |->
			o_t_addr[xbar_pkg::TGT_EXTERNAL_MEMORY_INTERFACE] >= `XB_EXT_BASE && o_t_addr[xbar_pkg::TGT_EXTERNAL_MEMORY_INTERFACE] <= `XB_EXT_END)
		else $error("external memory request outside its window");

	audio_word_only_a: assert property (o_t_req[xbar_pkg::TGT_AUDIO] |-> !o_t_byte[xbar_pkg::TGT_AUDIO])
		else $error("byte access reached the audio bus");

	onchip_decode_range_a: assert property (o_t_req[xbar_pkg::TGT_ONCHIP] |->
			(o_t_addr[xbar_pkg::TGT_ONCHIP] <= `XB_ROM_END ||
			o_t_addr[xbar_pkg::TGT_ONCHIP] >= `XB_RAM_BASE))
		else $error("on-chip request outside memory windows");

	bridge_hold_a: assert property (o_memory_bridge_reset && $past(o_memory_bridge_reset) &&
			o_t_req[xbar_pkg::TGT_ONCHIP] |->
			(cur.own_idx[xbar_pkg::TGT_ONCHIP] == `XB_M_CPU || cur.own_idx[xbar_pkg::TGT_ONCHIP] == `XB_M_PFILL))
		else $error("memory bridge passed DMA or host traffic while in reset");

	ext_pfill_last_a: assert property (!cur.own_vld[xbar_pkg::TGT_EXTERNAL_MEMORY_INTERFACE] &&
			tgt_req[xbar_pkg::TGT_EXTERNAL_MEMORY_INTERFACE][`XB_M_PFILL] && |tgt_req[xbar_pkg::TGT_EXTERNAL_MEMORY_INTERFACE][3:0] |=>
			cur.own_idx[xbar_pkg::TGT_EXTERNAL_MEMORY_INTERFACE] != `XB_M_PFILL)
		else $error("program fill won external memory over another master");

	generate
		for (gt = 0; gt < `XB_NUM_TGT; gt++) begin : g_chk_t
			owner_held_a: assert property (o_t_req[gt] && !i_t_ack[gt] &&
					!(gt == int'(xbar_pkg::TGT_ONCHIP) && abort_onchip) |=>
					o_t_req[gt] && $stable(o_t_addr[gt]) && $stable(cur.own_idx[gt]))
				else $error("target ownership changed before completion");
			top_prio_wins_a: assert property (!cur.own_vld[gt] && tgt_req[gt][`XB_M_CPU] |=>
					o_t_req[gt] && cur.own_idx[gt] == `XB_M_CPU)
				else $error("highest priority requester not granted");
			hi_over_lo_a: assert property (!cur.own_vld[gt] && tgt_req[gt][`XB_M_HIDMA] &&
					!tgt_req[gt][`XB_M_CPU] |=> cur.own_idx[gt] == `XB_M_HIDMA)
				else $error("high priority DMA port lost arbitration");
		end
		for (gm = 0; gm < `XB_NUM_MST; gm++) begin : g_chk_m
			unmapped_zero_a: assert property (elig[gm] && tgt_sel[gm] == xbar_pkg::TGT_NONE |=>
					o_m_ack[gm] && o_m_rdata[gm] == '0)
				else $error("unmapped access not completed with zero");
			bridge_write_a: assert property (elig[gm] && i_m_we[gm] && tgt_sel[gm] == xbar_pkg::TGT_LOCAL |=>
					o_memory_bridge_reset == $past(i_m_wdata[gm][`XB_BRIDGE_RST_BIT]) && o_m_ack[gm])
				else $error("bridge control write not applied");
		end
	endgenerate

	parallel_targets_c: cover property (o_t_req[xbar_pkg::TGT_AUDIO] && o_t_req[xbar_pkg::TGT_PERIPH] &&
		o_t_req[xbar_pkg::TGT_ONCHIP] && o_t_req[xbar_pkg::TGT_EXTERNAL_MEMORY_INTERFACE]);
	contention_c: cover property (tgt_req[xbar_pkg::TGT_PERIPH][`XB_M_HIDMA] &&
		tgt_req[xbar_pkg::TGT_PERIPH][`XB_M_LODMA] && !cur.own_vld[xbar_pkg::TGT_PERIPH]);
	unmapped_c: cover property (elig[`XB_M_HOST] && tgt_sel[`XB_M_HOST] == xbar_pkg::TGT_NONE);
	bridge_release_c: cover property ($fell(o_memory_bridge_reset) ##[1:20] o_t_req[xbar_pkg::TGT_ONCHIP]);

endmodule // xbar_switch

/* xbar_tgt_model.sv */
// Purpose: Behavioural model of the five target groups behind the switch.
// Assumes: One clock; a held request is answered after i_dly idle cycles.
// Notes:   Read data is the address with a fixed pattern folded in.
`timescale 1ns/1ps
`include "xbar_defs.svh"
module xbar_tgt_model (
	input  wire logic                         i_sys_clk,
	input  wire logic                         i_rst_n,
	input  wire logic [3:0]                   i_dly,
	input  wire logic [`XB_NUM_TGT-1:0]       i_req,
	input  wire logic [`XB_NUM_TGT-1:0][31:0] i_addr,
	output logic      [`XB_NUM_TGT-1:0]       o_ack,
	output logic      [`XB_NUM_TGT-1:0][31:0] o_rdata
);
	logic [`XB_NUM_TGT-1:0][3:0] wait_cnt;
	// =====================================================================
	// Answer
	// Between answers the data lines toggle, so a stale value never passes for a read.
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ack    <= '0;
			o_rdata  <= '0;
			wait_cnt <= '0;
		end else begin
			for (int t = 0; t < `XB_NUM_TGT; t++) begin
				o_ack[t]    <= i_req[t] && !o_ack[t] && wait_cnt[t] == i_dly;
				o_rdata[t]  <= (i_req[t] && !o_ack[t] && wait_cnt[t] == i_dly) ? (i_addr[t] ^ 32'h5A5A_0000) : ~o_rdata[t];
				wait_cnt[t] <= (i_req[t] && !o_ack[t] && wait_cnt[t] != i_dly) ? wait_cnt[t] + 4'h1 : 4'h0;
			end
		end
	end
endmodule // xbar_tgt_model
